/* rtl/aoc_config_bank.sv */
// Start-up configuration bank of a multi-channel analog output unit.
// Assumes the host parameter port and unitRestart are on clk_sys; the mode switch is a pin.
//
// Summary of operation
// - On eight-channel models mode code 00h selects normal and C1h selects adjustment.
// - On two- and four-channel models the mode comes from the front-panel switch.
// - Written settings take effect only at reset or unit restart, never on a plain write.
// - The enable word holds one bit per channel, output 1 at bit 0 to output 8 at bit 7.
// - Each channel's stop code selects clear (0), hold last (1) or maximum (2).
// - Outputs 3 and 4 exist on four- and eight-channel models, 5 to 8 on eight only.
// - A single 16-bit range word is kept, readable and writable by the host.
// - Configuration moves from host copy into the unit only at reset or restart.
`timescale 1ns/1ns
module aoc_config_bank #(
    parameter int CHANNEL_COUNT = 8
) (
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire logic                       unitRestart,
    input  wire logic                       modeSwitchPin,
    input  wire logic                       paramWrite,
    input  wire logic                       paramRead,
    input  wire logic [aoc_pkg::IDX_W-1:0]  paramIndex,
    input  wire logic [15:0]                paramWriteData,
    output logic      [15:0]                paramReadData,
    output logic                            paramReadValid,
    output logic                            adjustMode,
    output logic      [aoc_pkg::NUM_CH-1:0] channelEnable,
    output logic      [15:0]                outputRange,
    output logic      [aoc_pkg::NUM_CH-1:0] clearOnStop,
    output logic      [aoc_pkg::NUM_CH-1:0] holdOnStop,
    output logic      [aoc_pkg::NUM_CH-1:0] maxOnStop,
    output logic                            configError
);
    import aoc_pkg::*;

    aoc_state_s        st;
    aoc_state_s        next_st;
    logic [NUM_CH-1:0] chPresent;
    logic [NUM_CH-1:0] codeBad;
    logic              modeBad;

    // ------------------------------------------------------------------
    // Model channel map
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            chPresent[i] = (i < CHANNEL_COUNT);
        end
    end

    // ------------------------------------------------------------------
    // Host copy, load into active configuration, read-back
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Pin passes two flops before anything looks at it
        next_st.swMeta = modeSwitchPin;
        next_st.swSync = st.swMeta;

        if (paramWrite) begin
            if (paramIndex == IDX_MODE) begin
                next_st.modeSel = paramWriteData[7:0];
            end
            if (paramIndex == IDX_ENABLE) begin
                next_st.enableWord = paramWriteData & ENABLE_MASK;
            end
            if (paramIndex == IDX_RANGE) begin
                next_st.rangeWord = paramWriteData;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (paramIndex == IDX_STOP_FIRST + IDX_W'(i)) begin
                    next_st.stopSel[i] = paramWriteData[7:0];
                end
            end
        end

        // Read answer one cycle later; the host reads its own copy
        next_st.readValid = paramRead;
        next_st.readData  = READ_ZERO;
        if (paramRead) begin
            if (paramIndex == IDX_MODE) begin
                next_st.readData = {8'h00, st.modeSel};
            end
            if (paramIndex == IDX_ENABLE) begin
                next_st.readData = st.enableWord & ENABLE_MASK;
            end
            if (paramIndex == IDX_RANGE) begin
                next_st.readData = st.rangeWord;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (paramIndex == IDX_STOP_FIRST + IDX_W'(i)) begin
                    next_st.readData = {8'h00, st.stopSel[i]};
                end
            end
        end

        // Load uses the host copy as it stood before this cycle's write
        next_st.loadPending = unitRestart;
        if (st.loadPending) begin
            next_st.actMode  = st.modeSel;
            next_st.actRange = st.rangeWord;
            for (int i = 0; i < NUM_CH; i++) begin
                next_st.actEnable[i] = st.enableWord[i] & chPresent[i];
                next_st.actStop[i]   = st.stopSel[i];
            end
            if (CHANNEL_COUNT == FULL_MODEL) begin
                next_st.actAdjust = (st.modeSel == MODE_ADJUST);
            end else begin
                next_st.actAdjust = st.swSync;
            end
        end
    end

    // Load is pending out of reset so the first edge after release applies the copy
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st             <= '0;
            st.loadPending <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel stop-state decode
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : gStop
        aoc_stop_decode uDecode (
            .chPresent   (chPresent[g]),
            .chEnable    (st.actEnable[g]),
            .code        (st.actStop[g]),
            .clearOnStop (clearOnStop[g]),
            .holdOnStop  (holdOnStop[g]),
            .maxOnStop   (maxOnStop[g]),
            .codeBad     (codeBad[g])
        );
    end

    // On eight-channel models undefined mode codes run as normal but are flagged
    assign modeBad = (CHANNEL_COUNT == FULL_MODEL)
                   && (st.actMode != MODE_NORMAL) && (st.actMode != MODE_ADJUST);

    assign adjustMode     = st.actAdjust;
    assign channelEnable  = st.actEnable;
    assign outputRange    = st.actRange;
    assign paramReadData  = st.readData;
    assign paramReadValid = st.readValid;
    assign configError    = modeBad | (|codeBad);

endmodule

/* rtl/aoc_pkg.sv */
// Constants and types for the analog output start-up configuration bank.
// Assumes one system clock; the host reaches the bank over a word-wide parameter port.
package aoc_pkg;

    // ------------------------------------------------------------------
    // Parameter port indices
    // ------------------------------------------------------------------
    localparam int         IDX_W          = 4;
    localparam logic [3:0] IDX_MODE       = 4'h0;
    localparam logic [3:0] IDX_ENABLE     = 4'h1;
    localparam logic [3:0] IDX_RANGE      = 4'h2;
    localparam logic [3:0] IDX_STOP_FIRST = 4'h3;

    // ------------------------------------------------------------------
    // Field layouts and codes
    // ------------------------------------------------------------------
    localparam int          NUM_CH       = 8;
    localparam int          FULL_MODEL   = 8;
    localparam logic [15:0] ENABLE_MASK  = 16'h00FF;
    localparam logic [7:0]  MODE_NORMAL  = 8'h00;
    localparam logic [7:0]  MODE_ADJUST  = 8'hC1;
    localparam logic [7:0]  STOP_CLEAR   = 8'h00;
    localparam logic [7:0]  STOP_HOLD    = 8'h01;
    localparam logic [7:0]  STOP_MAX     = 8'h02;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RESET_ENABLE = 16'h0000;
    localparam logic [15:0] RESET_RANGE  = 16'h0000;
    localparam logic [15:0] READ_ZERO    = 16'h0000;

    typedef logic [NUM_CH-1:0][7:0] aoc_stop_t;

    typedef struct packed {
        logic [7:0]        modeSel;
        logic [15:0]       enableWord;
        logic [15:0]       rangeWord;
        aoc_stop_t         stopSel;
        logic [7:0]        actMode;
        logic [NUM_CH-1:0] actEnable;
        logic [15:0]       actRange;
        aoc_stop_t         actStop;
        logic              actAdjust;
        logic              loadPending;
        logic              swMeta;
        logic              swSync;
        logic [15:0]       readData;
        logic              readValid;
    } aoc_state_s;

endpackage

/* rtl/aoc_stop_decode.sv */
// One channel's decode of its active stop-state code into one-hot controls.
// Assumes the code and the enable come from registered active configuration.
`timescale 1ns/1ns
module aoc_stop_decode (
    input  wire logic       chPresent,
    input  wire logic       chEnable,
    input  wire logic [7:0] code,
    output logic            clearOnStop,
    output logic            holdOnStop,
    output logic            maxOnStop,
    output logic            codeBad
);
    import aoc_pkg::*;

    always_comb begin
        clearOnStop = 1'b0;
        holdOnStop  = 1'b0;
        maxOnStop   = 1'b0;
        codeBad     = 1'b0;
        if (chPresent && chEnable) begin
            unique case (code)
                STOP_CLEAR: clearOnStop = 1'b1;
                STOP_HOLD:  holdOnStop  = 1'b1;
                STOP_MAX:   maxOnStop   = 1'b1;
                default: begin
                    // Unknown code falls back to clearing, the safest output
                    clearOnStop = 1'b1;
                    codeBad     = 1'b1;
                end
            endcase
        end
    end

endmodule

/* tb/aoc_config_bank_assertions.sv */
// Port checker for the configuration bank.
// Assumes it is bound to every bank instance on one clock.
`timescale 1ns/1ns
module aoc_config_bank_assertions
    import aoc_pkg::*;
#(
    parameter int CHANNEL_COUNT = 8
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        unitRestart,
    input wire logic        modeSwitchPin,
    input wire logic        paramWrite,
    input wire logic        paramRead,
    input wire logic [3:0]  paramIndex,
    input wire logic [15:0] paramWriteData,
    input wire logic [15:0] paramReadData,
    input wire logic        paramReadValid,
    input wire logic        adjustMode,
    input wire logic [7:0]  channelEnable,
    input wire logic [15:0] outputRange,
    input wire logic [7:0]  clearOnStop,
    input wire logic [7:0]  holdOnStop,
    input wire logic [7:0]  maxOnStop,
    input wire logic        configError
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_quiet; !unitRestart ##1 !unitRestart; endsequence
    sequence s_item; paramRead && paramIndex != IDX_RANGE; endsequence
    property p_rdv; paramRead |=> paramReadValid; endproperty
    a_rdv: assert property (p_rdv) else $error("read not answered");
    property p_nrd; !paramRead |=> !paramReadValid && paramReadData == 16'h0000; endproperty
    a_nrd: assert property (p_nrd) else $error("stray read data");
    property p_hold; s_quiet |=> $stable(outputRange) && $stable(channelEnable); endproperty
    a_hold: assert property (p_hold) else $error("active config moved");
    property p_adj; CHANNEL_COUNT == 8 && $changed(adjustMode) |-> $past(unitRestart, 2);
    endproperty
    a_adj: assert property (p_adj) else $error("mode moved without apply");
    property p_msk; (channelEnable >> CHANNEL_COUNT) == 8'h00; endproperty
    a_msk: assert property (p_msk) else $error("absent channel enabled");
    property p_oh; (clearOnStop | holdOnStop | maxOnStop) == channelEnable; endproperty
    a_oh: assert property (p_oh) else $error("stop control missing");
    property p_ex; ((clearOnStop & holdOnStop) | (maxOnStop & (clearOnStop | holdOnStop)))
        == 8'h00; endproperty
    a_ex: assert property (p_ex) else $error("stop controls overlap");
    property p_r9; s_item |=> paramReadData[15:8] == 8'h00; endproperty
    a_r9: assert property (p_r9) else $error("upper byte not zero");
endmodule
bind aoc_config_bank aoc_config_bank_assertions #(.CHANNEL_COUNT(CHANNEL_COUNT)) i_chk (.*);

/* tb/aoc_host_model.sv */
// Host controller model driving the parameter port and restart.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
module aoc_host_model (
    input  wire logic clk_sys,
    output logic        paramWrite,
    output logic        paramRead,
    output logic [3:0]  paramIndex,
    output logic [15:0] paramWriteData,
    output logic        unitRestart
);
    initial begin
        {paramWrite, paramRead, unitRestart, paramIndex, paramWriteData} = 23'h0;
    end
    // Released index and data lines show the inverse so stale values cannot pass for held ones
    task automatic op(input logic w, input logic [3:0] i, input logic [15:0] d);
        @(posedge clk_sys) #1;
        {paramWrite, paramRead, paramIndex, paramWriteData} = {w, !w, i, d};
        @(posedge clk_sys) #1;
        {paramWrite, paramRead, paramIndex, paramWriteData} = {2'h0, ~i, ~d};
    endtask
    task automatic restart();
        @(posedge clk_sys) #1;
        unitRestart = 1'b1;
        @(posedge clk_sys) #1;
        unitRestart = 1'b0;
    endtask
endmodule

/* tb/aoc_config_bank_tb.sv */
// Self-checking bench for the configuration bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
module aoc_config_bank_tb;
    import aoc_pkg::*;
    logic clk_sys, resetn, wr, rd, rs, adj, rdv, err;
    logic [3:0] idx;
    logic [15:0] wd, rdat, rng, r, e;
    logic [7:0] en, clr, hld, mx;
    logic [15:0] q[$];
    int n_fail = 0;
    int check_count = 0;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    aoc_host_model i_aoc_host_model (.clk_sys(clk_sys), .paramWrite(wr), .paramRead(rd),
        .paramIndex(idx), .paramWriteData(wd), .unitRestart(rs));
    aoc_config_bank i_aoc_config_bank (.clk_sys(clk_sys), .resetn(resetn), .unitRestart(rs),
        .modeSwitchPin(1'b0), .paramWrite(wr), .paramRead(rd), .paramIndex(idx),
        .paramWriteData(wd), .paramReadData(rdat), .paramReadValid(rdv), .adjustMode(adj),
        .channelEnable(en), .outputRange(rng), .clearOnStop(clr), .holdOnStop(hld),
        .maxOnStop(mx), .configError(err));
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        check_count++;
        if (s !== x) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic rdx(input logic [3:0] i, input logic [15:0] x);
        q.push_back(x);
        i_aoc_host_model.op(1'b0, i, 16'h0000);
    endtask
    // Read answers stand one full cycle, so look at them mid-cycle where they are settled
    always @(negedge clk_sys) begin
        if (rdv === 1'b1) chk(rdat, q.pop_front());
    end
    task automatic setup(input logic [7:0] m);
        i_aoc_host_model.op(1'b1, IDX_MODE, {8'h00, m});
        i_aoc_host_model.restart();
        repeat (2) @(posedge clk_sys);
        #1 chk(adj, m == MODE_ADJUST);
    endtask
    initial begin
        #100000 n_fail++;
        close_out();
    end
    initial begin
        resetn = 1'b0;
        void'($urandom(55526));
        for (int k = 0; k < 2; k++) begin
            resetn = 1'b0;
            repeat (8) @(posedge clk_sys);
            #1 resetn = 1'b1;
            for (int i = 0; i < 16; i++) rdx(i, 16'h0000);
            if (k == 1) break;
            r = $urandom;
            i_aoc_host_model.op(1'b1, IDX_RANGE, r);
            i_aoc_host_model.op(1'b1, IDX_ENABLE, 16'hFFFF);
            for (int c = 0; c < 8; c++) i_aoc_host_model.op(1'b1, IDX_STOP_FIRST + c, c % 3);
            rdx(IDX_RANGE, r);
            rdx(IDX_ENABLE, ENABLE_MASK);
            for (int c = 0; c < 8; c++) rdx(IDX_STOP_FIRST + c, c % 3);
            chk(rng, 16'h0000);
            setup(MODE_ADJUST);
            chk(rng, r);
            chk(en, 8'hFF);
            e = '0;
            for (int c = 0; c < 8; c++) e[c] = (c % 3 == 0);
            chk(clr, e);
            chk(hld, e << 1);
            chk(mx, (e << 2) & 16'h00FF);
            chk(err, 1'b0);
            setup(MODE_NORMAL);
        end
        chk(rng, 16'h0000);
        close_out();
    end
endmodule
